// File: core/bcd_pkg.sv
package bcd_pkg;

  // ==========================================================
  // Sensor code values (hall_in_1 is the most significant bit).
  // ==========================================================
  localparam logic [2:0] BCD_CODE_100 = 3'h4;  // Code 100.
  localparam logic [2:0] BCD_CODE_110 = 3'h6;  // Code 110.
  localparam logic [2:0] BCD_CODE_111 = 3'h7;  // Code 111.
  localparam logic [2:0] BCD_CODE_011 = 3'h3;  // Code 011.
  localparam logic [2:0] BCD_CODE_001 = 3'h1;  // Code 001.
  localparam logic [2:0] BCD_CODE_000 = 3'h0;  // Code 000.
  localparam logic [2:0] BCD_CODE_010 = 3'h2;  // Code 010.
  localparam logic [2:0] BCD_CODE_101 = 3'h5;  // Code 101.

  // ==========================================================
  // Phase one-hot patterns, bit 0 is phase 1.
  // ==========================================================
  localparam logic [2:0] BCD_PH1  = 3'h1;  // Phase 1 selected.
  localparam logic [2:0] BCD_PH2  = 3'h2;  // Phase 2 selected.
  localparam logic [2:0] BCD_PH3  = 3'h4;  // Phase 3 selected.
  localparam logic [2:0] BCD_NONE = 3'h0;  // No phase selected.

  // ==========================================================
  // Reset values of the drive outputs (all switches off).
  // ==========================================================
  localparam logic [2:0] BCD_UPPER_N_RST = 3'h7;  // Upper is active low.
  localparam logic [2:0] BCD_LOWER_RST   = 3'h0;  // Lower is active high.

  // ==========================================================
  // Timing of the clock and the recommended PWM timebase.
  // ==========================================================
  localparam int BCD_CLK_HZ     = 40000000;  // System clock rate.
  localparam int BCD_PWM_MIN_HZ = 20000;     // Lowest advised PWM rate.
  localparam int BCD_PWM_MAX_HZ = 30000;     // Highest advised PWM rate.
  // Advised spacing of cycle starts, in clock cycles.
  localparam int BCD_PWM_MAX_CYC = BCD_CLK_HZ / BCD_PWM_MIN_HZ;
  localparam int BCD_PWM_MIN_CYC =
    (BCD_CLK_HZ + BCD_PWM_MAX_HZ - 1) / BCD_PWM_MAX_HZ;

  // ==========================================================
  // Sampled input bundle.
  // ==========================================================
  typedef struct packed {
    logic [2:0] hall;       // Sensor code.
    logic       fwd;        // Forward direction.
    logic       sel_60;     // Sensor spacing select.
    logic       en;         // Enable level.
    logic       en_driven;  // Enable is being driven.
    logic       oc;         // Overcurrent flag.
    logic       start;      // Oscillator cycle start.
    logic       pwm_end;    // PWM compare end.
  } bcd_in_s;

  // Drive output bundle.
  typedef struct packed {
    logic [2:0] upper_n;  // Upper drives, active low.
    logic [2:0] lower;    // Lower drives, active high.
  } bcd_drive_s;

endpackage : bcd_pkg

// File: core/bcd_sector_decode.sv
// Combinational rotor position decoder: code to phase pair.
module bcd_sector_decode
  import bcd_pkg::*;
(
  // Sensor code and mode.
  input  wire logic [2:0] hall_code,
  input  wire logic       sel_60,
  input  wire logic       fwd,
  // Decoded position.
  output logic            code_valid,
  output logic [2:0]      upper_on,
  output logic [2:0]      lower_on
);

  // ==========================================================
  // Sector lookup: bit 3 is valid, bits 2:0 the sector index.
  // ==========================================================
  // Codes outside the selected set come from a broken sensor line.
  function automatic logic [3:0] sector_of(input logic [2:0] c,
                                           input logic       s60);
    logic [3:0] r;
    r = 4'h0;
    unique case (c)
      BCD_CODE_100: r = 4'h8;
      BCD_CODE_110: r = 4'h9;
      BCD_CODE_111: r = s60 ? 4'ha : 4'h0;
      BCD_CODE_010: r = s60 ? 4'h0 : 4'ha;
      BCD_CODE_011: r = 4'hb;
      BCD_CODE_001: r = 4'hc;
      BCD_CODE_000: r = s60 ? 4'hd : 4'h0;
      BCD_CODE_101: r = s60 ? 4'h0 : 4'hd;
    endcase
    return r;
  endfunction : sector_of

  // Forward pair per sector, upper in bits 5:3, lower in 2:0.
  function automatic logic [5:0] pair_of(input logic [2:0] sec);
    logic [5:0] p;
    p = {BCD_NONE, BCD_NONE};
    unique case (sec)
      3'h0: p = {BCD_PH1, BCD_PH3};
      3'h1: p = {BCD_PH2, BCD_PH3};
      3'h2: p = {BCD_PH2, BCD_PH1};
      3'h3: p = {BCD_PH3, BCD_PH1};
      3'h4: p = {BCD_PH3, BCD_PH2};
      3'h5: p = {BCD_PH1, BCD_PH2};
      default: p = {BCD_NONE, BCD_NONE};
    endcase
    return p;
  endfunction : pair_of

  // ==========================================================
  // Decode wires.
  // ==========================================================
  wire logic [3:0] sec_w  = sector_of(hall_code, sel_60);
  wire logic [5:0] pair_w = pair_of(sec_w[2:0]);

  // Invalid codes select no phase at all.
  assign code_valid = sec_w[3];
  // Reverse swaps upper and lower of each same phase.
  assign upper_on = !code_valid ? BCD_NONE :
                    (fwd ? pair_w[5:3] : pair_w[2:0]);
  assign lower_on = !code_valid ? BCD_NONE :
                    (fwd ? pair_w[2:0] : pair_w[5:3]);

endmodule : bcd_sector_decode

// File: core/bcd_commutator.sv
module bcd_commutator
  import bcd_pkg::*;
(
  // Clock and reset.
  input  wire logic clock,
  input  wire logic reset,
  // Rotor position sensors.
  input  wire logic hall_in_1,
  input  wire logic hall_in_2,
  input  wire logic hall_in_3,
  // Mode and run control.
  input  wire logic dir_forward,
  input  wire logic spacing_sel_60,
  input  wire logic enable_in,
  input  wire logic enable_driven,
  // Cycle timing and protection.
  input  wire logic cycle_start,
  input  wire logic pwm_compare_end,
  input  wire logic overcurrent,
  // Switch drives.
  output logic      upper_drive_phase1,
  output logic      upper_drive_phase2,
  output logic      upper_drive_phase3,
  output logic      lower_drive_phase1,
  output logic      lower_drive_phase2,
  output logic      lower_drive_phase3
);

  // ==========================================================
  // Input sampling.
  // ==========================================================
  bcd_in_s    in_reg;       // Inputs taken on the last edge.
  bcd_in_s    in_next;      // Inputs as seen now.
  logic       pwm_lat_reg;  // Latch ended by the PWM compare.
  logic       oc_lat_reg;   // Latch ended by overcurrent.
  bcd_drive_s drv_reg;      // Registered drive outputs.

  assign in_next = '{hall: {hall_in_1, hall_in_2, hall_in_3},
                     fwd: dir_forward, sel_60: spacing_sel_60,
                     en: enable_in, en_driven: enable_driven,
                     oc: overcurrent, start: cycle_start,
                     pwm_end: pwm_compare_end};

  // Every input passes one register before use.
  always_ff @(posedge clock)
  begin
    if (reset)
      in_reg <= '0;
    else
      in_reg <= in_next;
  end

  // ==========================================================
  // Position decode.
  // ==========================================================
  logic       dec_valid;  // Sampled code is a valid position.
  logic [2:0] dec_upper;  // Upper phase to switch on.
  logic [2:0] dec_lower;  // Lower phase to switch on.

  bcd_sector_decode u_decode (
    .hall_code  (in_reg.hall),
    .sel_60     (in_reg.sel_60),
    .fwd        (in_reg.fwd),
    .code_valid (dec_valid),
    .upper_on   (dec_upper),
    .lower_on   (dec_lower)
  );

  // A floating enable pin is pulled up, so undriven means run.
  wire logic run_w = !in_reg.en_driven || in_reg.en;

  // ==========================================================
  // Dual latch pulse control.
  // ==========================================================
  // Both latches are set only by a cycle start, so a pulse that
  // ended cannot restart before the next cycle. A reset event
  // beats a set in the same cycle: an overcurrent still present
  // at a cycle start must keep the switches off.
  wire logic oc_lat_next  = in_reg.oc ? 1'b0 :
                            (in_reg.start ? 1'b1 : oc_lat_reg);
  wire logic pwm_lat_next = in_reg.pwm_end ? 1'b0 :
                            (in_reg.start ? 1'b1 : pwm_lat_reg);

  // Latch registers.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      oc_lat_reg  <= 1'b0;
      pwm_lat_reg <= 1'b0;
    end
    else
    begin
      oc_lat_reg  <= oc_lat_next;
      pwm_lat_reg <= pwm_lat_next;
    end
  end

  // ==========================================================
  // Drive gating.
  // ==========================================================
  // Uppers follow overcurrent only; PWM chops the lowers alone.
  wire logic upper_ok_w = dec_valid && run_w && oc_lat_next;
  wire logic lower_ok_w = upper_ok_w && pwm_lat_next;

  // An off switch takes its reset level, so idle and reset look
  // the same to the bridge and no leg is left half driven.
  wire logic [2:0] upper_n_w = upper_ok_w ? ~dec_upper
                                          : BCD_UPPER_N_RST;
  wire logic [2:0] lower_w   = lower_ok_w ? dec_lower
                                          : BCD_LOWER_RST;
  bcd_drive_s      drv_next;  // Drive pattern for the next edge.

  // One assignment fills the whole bundle, so it has one driver.
  assign drv_next = '{upper_n: upper_n_w, lower: lower_w};

  // Drive register; outputs come straight from it.
  always_ff @(posedge clock)
  begin
    if (reset)
      drv_reg <= '{upper_n: BCD_UPPER_N_RST, lower: BCD_LOWER_RST};
    else
      drv_reg <= drv_next;
  end

  assign upper_drive_phase1 = drv_reg.upper_n[0];
  assign upper_drive_phase2 = drv_reg.upper_n[1];
  assign upper_drive_phase3 = drv_reg.upper_n[2];
  assign lower_drive_phase1 = drv_reg.lower[0];
  assign lower_drive_phase2 = drv_reg.lower[1];
  assign lower_drive_phase3 = drv_reg.lower[2];

  // ==========================================================
  // Assertions.
  // ==========================================================
  // Raw inputs held steady for two edges reach the outputs.
  sequence s_raw_code(logic [2:0] c, logic f);
    {hall_in_1, hall_in_2, hall_in_3} == c && dir_forward == f &&
    spacing_sel_60 && enable_in && enable_driven && !overcurrent &&
    !pwm_compare_end && oc_lat_reg && pwm_lat_reg;
  endsequence

  AST_INVALID_OFF: assert property (
    @(posedge clock) disable iff (reset)
    !dec_valid |=> drv_reg.upper_n == 3'h7 && drv_reg.lower == 3'h0)
    else $error("Drive on with invalid sensor code.");

  AST_INVALID_SET: assert property (
    @(posedge clock) disable iff (reset)
    (in_reg.sel_60 && (in_reg.hall == 3'h5 || in_reg.hall == 3'h2)) ||
    (!in_reg.sel_60 && (in_reg.hall == 3'h7 || in_reg.hall == 3'h0))
    |-> !dec_valid)
    else $error("Invalid code decoded as position.");

  AST_COAST: assert property (
    @(posedge clock) disable iff (reset)
    in_reg.en_driven && !in_reg.en |=> drv_reg.lower == 3'h0 &&
    drv_reg.upper_n == 3'h7)
    else $error("Drive on while disabled.");

  AST_OC_HOLD: assert property (
    @(posedge clock) disable iff (reset)
    in_reg.oc ##1 !in_reg.start [*2] |=> drv_reg.lower == 3'h0 &&
    drv_reg.upper_n == 3'h7)
    else $error("Conduction resumed after overcurrent in cycle.");

  AST_ONE_PULSE: assert property (
    @(posedge clock) disable iff (reset)
    in_reg.pwm_end ##1 !in_reg.start |=> drv_reg.lower == 3'h0)
    else $error("Lower pulse restarted without a cycle start.");

  AST_UPPER_NO_PWM: assert property (
    @(posedge clock) disable iff (reset)
    dec_valid && run_w && oc_lat_next && !pwm_lat_next
    |=> drv_reg.lower == 3'h0 && drv_reg.upper_n != 3'h7)
    else $error("Upper drive chopped by PWM.");

  AST_PAIR: assert property (
    @(posedge clock) disable iff (reset)
    dec_valid |-> $onehot(dec_upper) && $onehot(dec_lower) &&
    (dec_upper & dec_lower) == 3'h0)
    else $error("Valid code gives no distinct phase pair.");

  AST_FWD_MAP: assert property (
    @(posedge clock) disable iff (reset)
    s_raw_code(3'h4, 1'b1) ##1 s_raw_code(3'h4, 1'b1)
    |=> drv_reg.upper_n == 3'h6 && drv_reg.lower == 3'h4)
    else $error("Forward code 100 not driving pair 1 over 3.");

  AST_REV_SWAP: assert property (
    @(posedge clock) disable iff (reset)
    s_raw_code(3'h4, 1'b0) ##1 s_raw_code(3'h4, 1'b0)
    |=> drv_reg.upper_n == 3'h3 && drv_reg.lower == 3'h1)
    else $error("Reverse did not swap phase pair.");

  AST_UNDRIVEN_RUN: assert property (
    @(posedge clock) disable iff (reset)
    !in_reg.en_driven && dec_valid && oc_lat_next
    |=> drv_reg.upper_n != 3'h7)
    else $error("Undriven enable stopped the motor.");

  // Reset must leave every switch off and both latches cleared,
  // so that the first pulse waits for a cycle start.
  AST_RESET_OFF: assert property (
    @(posedge clock)
    reset |=> drv_reg.upper_n == 3'h7 && drv_reg.lower == 3'h0 &&
    !oc_lat_reg && !pwm_lat_reg)
    else $error("Reset left a switch on or a latch set.");

  AST_START_RESUME: assert property (
    @(posedge clock) disable iff (reset)
    dec_valid && run_w && !in_reg.oc && !in_reg.pwm_end && in_reg.start
    |=> drv_reg.upper_n != 3'h7 && drv_reg.lower != 3'h0)
    else $error("Cycle start did not begin a conduction pulse.");

endmodule : bcd_commutator

// File: tb/bcd_sensor_bridge_model.sv
// ==========================================================
// Far side of the controller: sensors and power bridge.
// ==========================================================
module bcd_sensor_bridge_model
  import bcd_pkg::*;
(
  // Rotor position and sensor faults set by the bench.
  input  wire logic [2:0] rotor_code,
  input  wire logic [2:0] line_open,
  // Sensor lines into the controller.
  output logic [2:0]      hall_lines,
  // Drives out of the controller.
  input  wire bcd_drive_s drive,
  // Bridge state seen by the bench.
  output logic            shoot_through,
  output logic [2:0]      leg_high
);
  timeunit 1ns;
  timeprecision 1ps;

  // An open sensor line floats to the pull-up and reads 1.
  assign hall_lines = rotor_code | line_open;

  // Upper switch conducts on a low drive, lower on a high one.
  assign leg_high = ~drive.upper_n;
  // Both switches of one leg on would short the supply.
  assign shoot_through = |(~drive.upper_n & drive.lower);
endmodule : bcd_sensor_bridge_model

// File: tb/bldc_commutation_decoder_bench.sv
// ==========================================================
// Self-checking bench for the commutation logic.
// ==========================================================
module bldc_commutation_decoder_bench
  import bcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // One table row: mode, code and the phase pair in forward.
  typedef struct packed {
    logic       sel;   // Spacing select.
    logic [2:0] code;  // Sensor code.
    logic [2:0] up;    // Upper phase, one-hot.
    logic [2:0] lo;    // Lower phase, one-hot.
  } bcd_row_s;

  localparam bcd_drive_s OFF = '{upper_n: BCD_UPPER_N_RST,
                                 lower: BCD_LOWER_RST};
  localparam bcd_drive_s ON = '{upper_n: 3'h6, lower: 3'h4};

  // Rows with a zero pair are the invalid codes of each mode.
  localparam bcd_row_s ROWS [16] = '{
    '{1'b1, 3'h4, 3'h1, 3'h4}, '{1'b1, 3'h6, 3'h2, 3'h4},
    '{1'b1, 3'h7, 3'h2, 3'h1}, '{1'b1, 3'h3, 3'h4, 3'h1},
    '{1'b1, 3'h1, 3'h4, 3'h2}, '{1'b1, 3'h0, 3'h1, 3'h2},
    '{1'b1, 3'h5, 3'h0, 3'h0}, '{1'b1, 3'h2, 3'h0, 3'h0},
    '{1'b0, 3'h4, 3'h1, 3'h4}, '{1'b0, 3'h6, 3'h2, 3'h4},
    '{1'b0, 3'h2, 3'h2, 3'h1}, '{1'b0, 3'h3, 3'h4, 3'h1},
    '{1'b0, 3'h1, 3'h4, 3'h2}, '{1'b0, 3'h5, 3'h1, 3'h2},
    '{1'b0, 3'h7, 3'h0, 3'h0}, '{1'b0, 3'h0, 3'h0, 3'h0}};

  logic       clock;            // System clock.
  logic       reset;            // Synchronous reset.
  logic       dir_forward;      // Direction.
  logic       spacing_sel_60;   // Spacing select.
  logic       enable_in;        // Run or coast.
  logic       enable_driven;    // Low models a floating pin.
  logic       cycle_start;      // Oscillator cycle start.
  logic       pwm_compare_end;  // PWM compare end.
  logic       overcurrent;      // Current sense flag.
  logic [2:0] rotor_code;       // Rotor position code.
  logic [2:0] line_open;        // Broken sensor lines.
  logic [2:0] hall_lines;       // Sensor lines.
  wire  [2:0] upper_n_w;        // Upper drives.
  wire  [2:0] lower_w;          // Lower drives.
  logic       shoot_through;    // Leg short seen by bridge.
  int         err_count;        // Mismatches.
  int         check_count;      // Comparisons.
  wire bcd_drive_s drive_w = {upper_n_w, lower_w};

  bcd_commutator u_bcd_commutator (
    .clock(clock), .reset(reset),
    .hall_in_1(hall_lines[2]), .hall_in_2(hall_lines[1]),
    .hall_in_3(hall_lines[0]), .dir_forward(dir_forward),
    .spacing_sel_60(spacing_sel_60), .enable_in(enable_in),
    .enable_driven(enable_driven), .cycle_start(cycle_start),
    .pwm_compare_end(pwm_compare_end), .overcurrent(overcurrent),
    .upper_drive_phase1(upper_n_w[0]), .upper_drive_phase2(upper_n_w[1]),
    .upper_drive_phase3(upper_n_w[2]), .lower_drive_phase1(lower_w[0]),
    .lower_drive_phase2(lower_w[1]), .lower_drive_phase3(lower_w[2]));

  bcd_sensor_bridge_model u_bcd_sensor_bridge_model (
    .rotor_code(rotor_code), .line_open(line_open),
    .hall_lines(hall_lines), .drive(drive_w),
    .shoot_through(shoot_through), .leg_high());

  // Free-running 40 MHz clock.
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [5:0] seen,
                       input logic [5:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // Lets n edges pass and steps clear of them before sampling.
  task automatic wait_edges(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : wait_edges

  // Reverse swaps upper and lower of each phase.
  function automatic bcd_drive_s exp_drive(input bcd_row_s r,
                                           input logic fwd);
    return fwd ? {~r.up, r.lo} : {~r.lo, r.up};
  endfunction : exp_drive

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // A hang is cut short well past the expected run length.
  initial
  begin
    #(25 * 6000);
    err_count++;
    $display("watchdog expired");
    tally_and_finish();
  end

  // ==========================================================
  // Main sequence.
  // ==========================================================
  initial
  begin
    err_count = 0;
    check_count = 0;
    {reset, dir_forward, spacing_sel_60, enable_in} = 4'hf;
    {enable_driven, cycle_start, pwm_compare_end, overcurrent} = 4'h8;
    rotor_code = 3'h4;
    line_open = 3'h0;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    #1;
    check("reset drive", drive_w, OFF);
    // Latches start cleared, so nothing conducts before a start.
    wait_edges(3);
    check("no start yet", drive_w, OFF);
    @(posedge clock);
    cycle_start <= 1'b1;
    @(posedge clock);
    cycle_start <= 1'b0;
    $display("test reset done");
    // Every code in both modes and both directions.
    foreach (ROWS[i])
      for (int d = 0; d < 2; d++)
      begin
        @(posedge clock);
        spacing_sel_60 <= ROWS[i].sel;
        rotor_code <= ROWS[i].code;
        dir_forward <= d[0];
        wait_edges(2);
        check("drive", drive_w, exp_drive(ROWS[i], d[0]));
        check("leg short", {5'h00, shoot_through}, 6'h00);
      end
    $display("test table done");
    @(posedge clock);
    {spacing_sel_60, dir_forward, rotor_code} <= 5'h1c;
    wait_edges(2);
    check("code 100", drive_w, ON);
    @(posedge clock);
    enable_in <= 1'b0;
    wait_edges(1);
    check("enable latency", drive_w, ON);
    wait_edges(1);
    check("coast", drive_w, OFF);
    @(posedge clock);
    enable_driven <= 1'b0;
    wait_edges(2);
    check("floating enable", drive_w, ON);
    @(posedge clock);
    {enable_driven, enable_in} <= 2'h3;
    $display("test enable done");
    // A start while overcurrent is high must not restart conduction.
    @(posedge clock);
    overcurrent <= 1'b1;
    wait_edges(2);
    check("overcurrent", drive_w, OFF);
    @(posedge clock);
    cycle_start <= 1'b1;
    @(posedge clock);
    {cycle_start, overcurrent} <= 2'h0;
    // Off for a whole cycle at the fastest advised rate.
    repeat (BCD_PWM_MIN_CYC)
    begin
      wait_edges(1);
      check("held off", drive_w, OFF);
    end
    @(posedge clock);
    cycle_start <= 1'b1;
    @(posedge clock);
    cycle_start <= 1'b0;
    wait_edges(1);
    check("restart", drive_w, ON);
    $display("test overcurrent done");
    // Compare end chops only the lower drive, once per cycle.
    @(posedge clock);
    pwm_compare_end <= 1'b1;
    @(posedge clock);
    pwm_compare_end <= 1'b0;
    wait_edges(1);
    check("chop", drive_w, {3'h6, 3'h0});
    wait_edges(6);
    check("single pulse", drive_w, {3'h6, 3'h0});
    @(posedge clock);
    cycle_start <= 1'b1;
    @(posedge clock);
    cycle_start <= 1'b0;
    wait_edges(1);
    check("next pulse", drive_w, ON);
    $display("test pwm done");
    // A broken line turns 110 into 111, invalid at 120 spacing.
    @(posedge clock);
    {spacing_sel_60, rotor_code, line_open} <= 7'h31;
    wait_edges(2);
    check("open line", drive_w, OFF);
    @(posedge clock);
    line_open <= 3'h0;
    wait_edges(2);
    check("line mended", drive_w, {3'h5, 3'h4});
    $display("test sensor fault done");
    // A reset in mid-run clears both latches: nothing conducts
    // until the first cycle start after release.
    @(posedge clock);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    #1;
    check("mid reset", drive_w, OFF);
    wait_edges(2);
    check("idle after reset", drive_w, OFF);
    @(posedge clock);
    cycle_start <= 1'b1;
    @(posedge clock);
    cycle_start <= 1'b0;
    wait_edges(1);
    check("start after reset", drive_w, {3'h5, 3'h4});
    $display("test mid reset done");
    tally_and_finish();
  end
endmodule : bldc_commutation_decoder_bench
